// >>> counter_cfg.svh
// Purpose: Constants for the four-channel counter block.
// Assumes: 250 MHz pclk, APB register access.
// Notes: Offsets are byte addresses on an 8-bit paddr.
`ifndef COUNTER_CFG_SVH
`define COUNTER_CFG_SVH

`define CFG_CLK_MHZ 250
`define CFG_TICK_NS 100
`define CFG_TICK_CYC ((`CFG_TICK_NS * `CFG_CLK_MHZ) / 1000)
`define CFG_PRE_W 5
`define CFG_NCHAN 4

`define CFG_OFS_MODE 5'h00
`define CFG_OFS_RELOAD_A 5'h04
`define CFG_OFS_RELOAD_B 5'h08
`define CFG_OFS_RESULT 5'h0c
`define CFG_OFS_COUNT 5'h10
`define CFG_OFS_STATUS 5'h14
`define CFG_OFS_TRIG 5'h18
`define CFG_ADDR_GATE 8'h80

`define CFG_MODE_LSB 0
`define CFG_MODE_MSB 2
`define CFG_BIT_GATE_SRC 3
`define CFG_BIT_IDX_LOW 4
`define CFG_BIT_HW_TRIG 5
`define CFG_BIT_OUT_LOW 6
`define CFG_BIT_RUN 15
`define CFG_MODE_RESET 16'h0000

`define CFG_ST_VALID 0
`define CFG_ST_ACTIVE 1

`endif

// >>> counter_pkg.sv
// Purpose: Types shared by the counter block files.
// Assumes: Nothing beyond the configuration header.
// Notes: Codes 6 and 7 of the mode field are illegal and hold the channel's count and output.
package counter_pkg;

	typedef enum logic [2:0]
	{
		MODE_FREQ = 3'b000,
		MODE_PERIOD = 3'b001,
		MODE_ONESHOT = 3'b010,
		MODE_PULSEW = 3'b011,
		MODE_PWM = 3'b100,
		MODE_INTCLK = 3'b101
	} chan_mode_t;

endpackage

// >>> counter_chan.sv
// Purpose: One counter channel: measurement and generation modes.
// Assumes: Inputs are synchronous to pclk.
// Notes: All durations are in 0.1 us ticks from a per-channel prescaler.
`include "counter_cfg.svh"

module counter_chan (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [2:0] mode,
	input wire logic gate_src,
	input wire logic index_low_active_sel,
	input wire logic hw_trigger_enable,
	input wire logic output_polarity,
	input wire logic [31:0] reload_reg_a,
	input wire logic [31:0] reload_reg_b,
	input wire logic soft_trig,
	input wire logic gen_gate_rise,
	input wire logic count_input_a,
	input wire logic count_input_b,
	input wire logic index_in,
	output logic [31:0] count_reg,
	output logic [31:0] result_reg,
	output logic result_new,
	output logic active_reg,
	output logic chan_out
);

	logic prev_a_reg;
	logic prev_idx_reg;
	logic [`CFG_PRE_W-1:0] pre_reg;
	logic [31:0] count_next;
	logic [31:0] result_next;
	logic active_next;
	logic restart;
	wire tick = (pre_reg == `CFG_PRE_W'(`CFG_TICK_CYC - 1));
	wire a_rise = count_input_a & ~prev_a_reg;
	wire idx_act = index_in ^ index_low_active_sel;
	wire idx_prev_act = prev_idx_reg ^ index_low_active_sel;
	wire idx_rise = idx_act & ~idx_prev_act;
	wire idx_fall = ~idx_act & idx_prev_act;
	wire ext_gate_rise = index_in & ~prev_idx_reg;
	wire gate_rise = gate_src ? gen_gate_rise : ext_gate_rise;
	wire one_trig = soft_trig | (hw_trigger_enable & idx_rise);

	//////////////////////////////////////////////////////////////////
	always_comb
	begin
		count_next = count_reg;
		result_next = result_reg;
		active_next = active_reg;
		result_new = 1'b0;
		restart = 1'b0;
		if (!run)
		begin
			count_next = 32'h0;
			active_next = 1'b0;
			restart = 1'b1;
		end
		else
		begin
			unique case (mode)
				counter_pkg::MODE_FREQ:
				begin
					if (gate_rise)
					begin
						result_next = count_reg + {31'h0, a_rise};
						count_next = reload_reg_a;
						result_new = 1'b1;
					end
					else if (a_rise)
						count_next = count_reg + 32'h1;
				end
				counter_pkg::MODE_PERIOD:
				begin
					if (idx_rise)
					begin
						// A tick landing on the closing edge still belongs to this period.
						result_next = count_reg + {31'h0, tick};
						count_next = 32'h0;
						result_new = 1'b1;
						restart = 1'b1;
					end
					else if (tick)
						count_next = count_reg + 32'h1;
				end
				counter_pkg::MODE_ONESHOT:
				begin
					if (!active_reg)
					begin
						if (one_trig)
						begin
							active_next = 1'b1;
							count_next = reload_reg_a;
							restart = 1'b1;
						end
					end
					else if (tick)
					begin
						if (count_reg == 32'h0)
							active_next = 1'b0;
						else
							count_next = count_reg - 32'h1;
					end
				end
				counter_pkg::MODE_PULSEW:
				begin
					if (idx_fall)
					begin
						result_next = count_reg + {31'h0, tick};
						count_next = 32'h0;
						result_new = 1'b1;
					end
					else if (idx_rise)
					begin
						count_next = 32'h0;
						restart = 1'b1;
					end
					else if (idx_act && tick)
						count_next = count_reg + 32'h1;
				end
				counter_pkg::MODE_PWM:
				begin
					if (tick)
					begin
						if (count_reg == 32'h0)
						begin
							active_next = ~active_reg;
							count_next = active_reg ? reload_reg_a : reload_reg_b;
						end
						else
							count_next = count_reg - 32'h1;
					end
				end
				counter_pkg::MODE_INTCLK:
				begin
					if (tick && count_input_a)
						count_next = count_input_b ? count_reg - 32'h1 : count_reg + 32'h1;
				end
				default:
				begin
					count_next = count_reg;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev_a_reg <= 1'b0;
			prev_idx_reg <= 1'b0;
			pre_reg <= '0;
			count_reg <= 32'h0;
			result_reg <= 32'h0;
			active_reg <= 1'b0;
			chan_out <= 1'b0;
		end
		else
		begin
			prev_a_reg <= count_input_a;
			prev_idx_reg <= index_in;
			pre_reg <= (restart || tick) ? '0 : pre_reg + `CFG_PRE_W'(1);
			count_reg <= count_next;
			result_reg <= result_next;
			active_reg <= active_next;
			chan_out <= active_next ^ output_polarity;
		end
	end

	//////////////////////////////////////////////////////////////////
	sequence pwm_wrap_s;
		run && mode == counter_pkg::MODE_PWM && tick && count_reg == 32'h0;
	endsequence

	halt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		!run |=> count_reg == 32'h0 && !active_reg && chan_out == $past(output_polarity))
		else $error("halted channel not cleared");
	freq_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
		run && mode == counter_pkg::MODE_FREQ && gate_rise
		|=> result_reg == $past(count_reg) + {31'h0, $past(a_rise)} && count_reg == $past(reload_reg_a))
		else $error("frequency result not latched at gate edge");
	shot_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
		run && mode == counter_pkg::MODE_ONESHOT && active_reg && !tick
		|=> active_reg && count_reg == $past(count_reg))
		else $error("one-shot retriggered while busy");
	pulse_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
		run && mode == counter_pkg::MODE_PULSEW && idx_fall
		|=> result_reg == $past(count_reg) + {31'h0, $past(tick)} && count_reg == 32'h0)
		else $error("pulse width not latched");
	pwm_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
		pwm_wrap_s ##0 active_reg |=> !active_reg && count_reg == $past(reload_reg_a) ##1 chan_out == output_polarity)
		else $error("pwm phase switch wrong");

endmodule

// >>> counter_channels.sv
// Purpose: Four counter channels behind an APB slave, with a shared gate generator.
// Assumes: APB master per AMBA APB; inputs synchronous to pclk.
// Notes: The answer comes in the first cycle of the access phase; no wait states.
`include "counter_cfg.svh"

//////////////////////////////////////////////////////////////////////
module counter_channels (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] count_input_a,
	input wire logic [3:0] count_input_b,
	input wire logic [3:0] index_in,
	output logic [3:0] chan_out
);

	//////////////////////////////////////////////////////////////////
	// Address decoding.

	function automatic logic chan_hit(
		input logic [7:0] addr,
		input logic [1:0] chan,
		input logic [4:0] ofs
	);
		chan_hit = !addr[7] && addr[6:5] == chan && addr[4:0] == ofs;
	endfunction

	function automatic logic ofs_known(input logic [4:0] ofs);
		ofs_known = ofs == `CFG_OFS_MODE || ofs == `CFG_OFS_RELOAD_A
			|| ofs == `CFG_OFS_RELOAD_B || ofs == `CFG_OFS_RESULT
			|| ofs == `CFG_OFS_COUNT || ofs == `CFG_OFS_STATUS
			|| ofs == `CFG_OFS_TRIG;
	endfunction

	wire setup = psel && !penable;
	wire access_done = psel && penable && pready;
	wire wr_en = access_done && pwrite;
	wire rd_en = access_done && !pwrite;
	wire gate_hit = paddr == `CFG_ADDR_GATE;
	wire [1:0] sel_chan = paddr[6:5];
	wire [4:0] sel_ofs = paddr[4:0];
	wire addr_ok = gate_hit || (!paddr[7] && ofs_known(sel_ofs));

	//////////////////////////////////////////////////////////////////
	// Shared gate generator: a rising edge every (period + 1) ticks.

	logic [31:0] gate_period_reg;
	logic [31:0] gate_cnt_reg;
	logic [`CFG_PRE_W-1:0] gate_pre_reg;
	logic gen_rise_reg;
	wire gate_tick = gate_pre_reg == `CFG_PRE_W'(`CFG_TICK_CYC - 1);
	wire gate_wrap = gate_tick && gate_cnt_reg == 32'h0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gate_pre_reg <= '0;
			gate_cnt_reg <= 32'h0;
			gen_rise_reg <= 1'b0;
		end
		else
		begin
			gate_pre_reg <= gate_tick ? '0 : gate_pre_reg + `CFG_PRE_W'(1);
			if (gate_tick)
				gate_cnt_reg <= gate_wrap ? gate_period_reg : gate_cnt_reg - 32'h1;
			gen_rise_reg <= gate_wrap;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gate_period_reg <= 32'h0;
		else if (wr_en && gate_hit)
			gate_period_reg <= pwdata;
	end

	//////////////////////////////////////////////////////////////////
	// Per-channel registers and channel cores.

	logic [15:0] mode_reg [`CFG_NCHAN];
	logic [31:0] reload_a_reg [`CFG_NCHAN];
	logic [31:0] reload_b_reg [`CFG_NCHAN];
	logic [31:0] count_val [`CFG_NCHAN];
	logic [31:0] result_val [`CFG_NCHAN];
	logic [`CFG_NCHAN-1:0] valid_reg;
	logic [`CFG_NCHAN-1:0] result_new;
	logic [`CFG_NCHAN-1:0] active;

	genvar c;
	generate
		for (c = 0; c < `CFG_NCHAN; c++)
		begin : g_chan
			wire mode_wr = wr_en && chan_hit(paddr, 2'(c), `CFG_OFS_MODE);
			wire ra_wr = wr_en && chan_hit(paddr, 2'(c), `CFG_OFS_RELOAD_A);
			wire rb_wr = wr_en && chan_hit(paddr, 2'(c), `CFG_OFS_RELOAD_B);
			wire res_rd = rd_en && chan_hit(paddr, 2'(c), `CFG_OFS_RESULT);
			wire trig_wr = wr_en && chan_hit(paddr, 2'(c), `CFG_OFS_TRIG) && pwdata[0];
			wire run = mode_reg[c][`CFG_BIT_RUN];

			// Reload registers stay writable in every mode so PWM can be retuned live.
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					mode_reg[c] <= `CFG_MODE_RESET;
					reload_a_reg[c] <= 32'h0;
					reload_b_reg[c] <= 32'h0;
				end
				else
				begin
					if (mode_wr)
						mode_reg[c] <= pwdata[15:0];
					if (ra_wr)
						reload_a_reg[c] <= pwdata;
					if (rb_wr)
						reload_b_reg[c] <= pwdata;
				end
			end

			// A new result sets the flag even in the cycle software reads it.
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					valid_reg[c] <= 1'b0;
				else if (!run)
					valid_reg[c] <= 1'b0;
				else if (result_new[c])
					valid_reg[c] <= 1'b1;
				else if (res_rd)
					valid_reg[c] <= 1'b0;
			end

			counter_chan u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.run(run),
				.mode(mode_reg[c][`CFG_MODE_MSB:`CFG_MODE_LSB]),
				.gate_src(mode_reg[c][`CFG_BIT_GATE_SRC]),
				.index_low_active_sel(mode_reg[c][`CFG_BIT_IDX_LOW]),
				.hw_trigger_enable(mode_reg[c][`CFG_BIT_HW_TRIG]),
				.output_polarity(mode_reg[c][`CFG_BIT_OUT_LOW]),
				.reload_reg_a(reload_a_reg[c]),
				.reload_reg_b(reload_b_reg[c]),
				.soft_trig(trig_wr),
				.gen_gate_rise(gen_rise_reg),
				.count_input_a(count_input_a[c]),
				.count_input_b(count_input_b[c]),
				.index_in(index_in[c]),
				.count_reg(count_val[c]),
				.result_reg(result_val[c]),
				.result_new(result_new[c]),
				.active_reg(active[c]),
				.chan_out(chan_out[c])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////
	// Read data selection; reading never disturbs a channel core.

	logic [31:0] rd_value;

	always_comb
	begin
		rd_value = 32'h0;
		if (gate_hit)
			rd_value = gate_period_reg;
		else if (!paddr[7])
		begin
			unique case (sel_ofs)
				`CFG_OFS_MODE:
					rd_value = {16'h0, mode_reg[sel_chan]};
				`CFG_OFS_RELOAD_A:
					rd_value = reload_a_reg[sel_chan];
				`CFG_OFS_RELOAD_B:
					rd_value = reload_b_reg[sel_chan];
				`CFG_OFS_RESULT:
					rd_value = result_val[sel_chan];
				`CFG_OFS_COUNT:
					rd_value = count_val[sel_chan];
				`CFG_OFS_STATUS:
				begin
					rd_value[`CFG_ST_VALID] = valid_reg[sel_chan];
					rd_value[`CFG_ST_ACTIVE] = active[sel_chan];
				end
				default:
					rd_value = 32'h0;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////
	// APB answer: registered in the setup cycle, so pready is high in
	// the first access cycle and every transfer takes exactly two edges.

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !addr_ok;
			if (setup && (!pwrite || !addr_ok))
				prdata <= addr_ok ? rd_value : 32'h0;
		end
	end

	//////////////////////////////////////////////////////////////////
	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> pready && penable ##1 !pready)
		else $error("apb answer not in first access cycle");
	unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !addr_ok |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not flagged");
	gate_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		gen_rise_reg |=> !gen_rise_reg [*8])
		else $error("gate edges too close");

endmodule

// >>> pin_model.sv
// Purpose: Far-side pin model driving the index and clock-A inputs of all four channels.
// Assumes: Times are given in pclk cycles; zero high time holds index low, zero half period holds clock-A high.
// Notes: Pins change just after the rising edge, like a synchronised external source.
module pin_model (
	input wire logic pclk,
	input wire logic [15:0] idx_hi,
	input wire logic [15:0] idx_lo,
	input wire logic [15:0] a_half,
	output logic [3:0] index_in,
	output logic [3:0] count_input_a
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] icnt = 16'h0000;
	logic [15:0] acnt = 16'h0000;
	logic ilvl = 1'b0;
	logic alvl = 1'b1;

	assign index_in = {4{ilvl}};
	assign count_input_a = {4{alvl}};

	//////////////////////////////////////////////////////////////////////
	// A periodic gate whose active time differs from its period.
	always @(posedge pclk)
	begin
		icnt <= icnt + 16'h0001;
		if (idx_hi == 16'h0000)
			ilvl <= 1'b0;
		else if (icnt + 16'h0001 >= (ilvl ? idx_hi : idx_lo))
		begin
			ilvl <= ~ilvl;
			icnt <= 16'h0000;
		end
	end

	// Clock-A with an even duty cycle, so every period carries one rising edge.
	always @(posedge pclk)
	begin
		acnt <= acnt + 16'h0001;
		if (a_half == 16'h0000)
			alvl <= 1'b1;
		else if (acnt + 16'h0001 >= a_half)
		begin
			alvl <= ~alvl;
			acnt <= 16'h0000;
		end
	end
endmodule

// >>> counter_channel_measure_gen_modes_tb.sv
// Purpose: Self-checking bench for the four-channel counter block.
// Assumes: One tick is 25 pclk cycles; gate generator period register 3 gives a gate every 100 cycles.
// Notes: Register checks run from a table; mode scenarios follow by hand.
module counter_channel_measure_gen_modes_tb;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} row_t;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] cib = 4'h0;
	logic [3:0] cia;
	logic [3:0] idx;
	logic [3:0] chan_out;
	logic [15:0] idx_hi = 16'h0064;
	logic [15:0] idx_lo = 16'h0096;
	logic [15:0] a_half = 16'h0000;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	row_t rows [14] = '{
		'{8'h00, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h04, 1'b1, 32'h12345678, 32'h0, 1'b0},
		'{8'h04, 1'b0, 32'h0, 32'h12345678, 1'b0}, '{8'h68, 1'b1, 32'h0000abcd, 32'h0, 1'b0},
		'{8'h68, 1'b0, 32'h0, 32'h0000abcd, 1'b0}, '{8'h0c, 1'b1, 32'hffffffff, 32'h0, 1'b0},
		'{8'h0c, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h30, 1'b0, 32'h0, 32'h0, 1'b0},
		'{8'h1c, 1'b0, 32'h0, 32'h0, 1'b1}, '{8'h84, 1'b0, 32'h0, 32'h0, 1'b1},
		'{8'hf0, 1'b1, 32'h1, 32'h0, 1'b1}, '{8'h80, 1'b1, 32'h3, 32'h0, 1'b0},
		'{8'h80, 1'b0, 32'h0, 32'h3, 1'b0}, '{8'h74, 1'b0, 32'h0, 32'h0, 1'b0}};

	always #2 pclk = ~pclk;

	counter_channels dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.count_input_a(cia),
		.count_input_b(cib),
		.index_in(idx),
		.chan_out(chan_out)
	);

	pin_model far (
		.pclk(pclk),
		.idx_hi(idx_hi),
		.idx_lo(idx_lo),
		.a_half(a_half),
		.index_in(idx),
		.count_input_a(cia)
	);

	//////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// The request is held until pready is sampled high; data and error are taken at that edge.
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(a, 1'b1, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(a, 1'b0, 32'h0, r, e);
		check(r, x);
	endtask

	// The channel is halted first so that it starts its new mode from a clean state.
	task automatic setm(input logic [7:0] a, input logic [31:0] m);
		wr(a, m & 32'h00007fff);
		wr(a, m);
	endtask

	// Length of the next complete phase at level lvl, in cycles.
	task automatic phase(input int c, input logic lvl, output int w);
		int n;
		n = 0;
		w = 0;
		while (chan_out[c] === lvl && n < 4000) @(posedge pclk) n++;
		while (chan_out[c] !== lvl && n < 8000) @(posedge pclk) n++;
		while (chan_out[c] === lvl && w < 4000) @(posedge pclk) w++;
	endtask

	task automatic quiet(input int c, input logic lvl, input int n, output int k);
		k = 0;
		repeat (n) @(posedge pclk) k += (chan_out[c] !== lvl);
	endtask

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			failures++;
			close_out();
		end
	end

	//////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] r;
		logic [31:0] r1;
		logic e;
		int w;
		int k;
		repeat (5) @(posedge pclk);
		check({28'h0, chan_out}, 32'h0);
		check({31'h0, pready}, 32'h0);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i])
		begin
			apb(rows[i].a, rows[i].w, rows[i].d, r, e);
			check(rows[i].w ? 32'h0 : r, rows[i].x);
			check({31'h0, e}, {31'h0, rows[i].e});
		end
		wr(8'h04, 32'h1);
		setm(8'h00, 32'h8002);
		wr(8'h18, 32'h1);
		fork
			phase(0, 1'b1, w);
			begin
				repeat (12) @(posedge pclk);
				wr(8'h18, 32'h1);
			end
		join
		check(w, 50);
		quiet(0, 1'b0, 300, k);
		check(k, 0);
		setm(8'h00, 32'h8042);
		repeat (3) @(posedge pclk);
		check({31'h0, chan_out[0]}, 32'h1);
		wr(8'h18, 32'h1);
		phase(0, 1'b0, w);
		check(w, 50);
		setm(8'h00, 32'h8022);
		phase(0, 1'b1, w);
		check(w, 50);
		// Loading both reloads before the run bit keeps the first phases defined.
		wr(8'h24, 32'h1);
		wr(8'h28, 32'h0);
		setm(8'h20, 32'h8004);
		phase(1, 1'b1, w);
		check(w, 25);
		phase(1, 1'b0, w);
		check(w, 50);
		wr(8'h28, 32'h2);
		phase(1, 1'b1, w);
		phase(1, 1'b1, w);
		check(w, 75);
		wr(8'h20, 32'h4);
		rd(8'h30, 32'h0);
		rd(8'h34, 32'h0);
		rd(8'h28, 32'h2);
		quiet(1, 1'b0, 100, k);
		check(k, 0);
		setm(8'h00, 32'h8005);
		apb(8'h10, 1'b0, 32'h0, r1, e);
		repeat (247) @(posedge pclk);
		apb(8'h10, 1'b0, 32'h0, r, e);
		check(r - r1, 32'ha);
		cib <= 4'h1;
		repeat (30) @(posedge pclk);
		apb(8'h10, 1'b0, 32'h0, r1, e);
		repeat (247) @(posedge pclk);
		apb(8'h10, 1'b0, 32'h0, r, e);
		check(r - r1, 32'hfffffff6);
		setm(8'h60, 32'h8001);
		repeat (800) @(posedge pclk);
		rd(8'h6c, 32'ha);
		setm(8'h60, 32'h8011);
		repeat (800) @(posedge pclk);
		rd(8'h6c, 32'ha);
		setm(8'h60, 32'h8003);
		repeat (800) @(posedge pclk);
		rd(8'h6c, 32'h4);
		rd(8'h6c, 32'h4);
		setm(8'h60, 32'h8013);
		repeat (800) @(posedge pclk);
		rd(8'h6c, 32'h6);
		// The frequency restart value stays at its reset value of zero.
		a_half <= 16'h0005;
		setm(8'h40, 32'h8008);
		repeat (500) @(posedge pclk);
		rd(8'h4c, 32'ha);
		setm(8'h40, 32'h8000);
		repeat (900) @(posedge pclk);
		rd(8'h4c, 32'h19);
		idx_hi <= 16'h0014;
		idx_lo <= 16'h00b4;
		setm(8'h40, 32'h8010);
		repeat (900) @(posedge pclk);
		rd(8'h4c, 32'h14);
		close_out();
	end
endmodule
